/* File: edpc_monitor.sv */
`timescale 1ns/10ps
module edpc_monitor #(
    parameter int IDLE_CYCLES = 200
) (
    input wire logic        i_mclk,
    input wire logic        i_reset,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic        pready,
    input wire logic [31:0] prdata,
    input wire logic        pslverr,
    input wire logic        o_line_driver_on,
    input wire logic        o_sense_pulse,
    input wire logic        o_irq
);
    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (i_reset);
    logic acc;
    logic setup;
    logic wr_acc;
    logic mapped;
    assign acc    = psel && penable;
    assign setup  = psel && !penable;
    assign wr_acc = acc && pwrite;
    assign mapped = paddr inside {12'h000, 12'h004, 12'h008, 12'h00c};
    property p_ready; acc |-> pready; endproperty
    a_ready: assert property (p_ready) else $error("pready low in access");
    property p_unmapped; acc && !mapped && !pwrite |-> pslverr && prdata == 32'h0; endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped read not refused");
    property p_mapped; acc && mapped |-> !pslverr; endproperty
    a_mapped: assert property (p_mapped) else $error("error on mapped access");
    property p_ctrl_rd; acc && !pwrite && paddr == 12'h000 |-> prdata[31:16] == 16'h0
        && !prdata[12]; endproperty
    a_ctrl_rd: assert property (p_ctrl_rd) else $error("control read bad bits");
    property p_clr_rd; acc && !pwrite && paddr == 12'h008 |-> prdata == 32'h0; endproperty
    a_clr_rd: assert property (p_clr_rd) else $error("clear register read not zero");
    property p_hold; $changed(prdata) |-> $past(setup); endproperty
    a_hold: assert property (p_hold) else $error("read data moved outside setup");
    property p_gap; o_sense_pulse |=> !o_sense_pulse [*8]; endproperty
    a_gap: assert property (p_gap) else $error("pulses too close");
    property p_drv; o_sense_pulse |-> o_line_driver_on; endproperty
    a_drv: assert property (p_drv) else $error("pulse with driver off");
    property p_irq; $fell(o_irq) |-> $past(wr_acc, 1) || $past(wr_acc, 2); endproperty
    a_irq: assert property (p_irq) else $error("interrupt fell without a write");
endmodule
bind edpc_top edpc_monitor #(.IDLE_CYCLES(IDLE_CYCLES)) mon (.i_mclk(i_mclk),
    .i_reset(i_reset), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pready(pready), .prdata(prdata), .pslverr(pslverr), .o_irq(o_irq),
    .o_line_driver_on(o_line_driver_on), .o_sense_pulse(o_sense_pulse));

/* File: edpc_partner.sv */
`timescale 1ns/10ps
module edpc_partner (
    input  wire logic i_mclk,
    output logic      o_data_event,
    output logic      o_error_event,
    output logic      o_energy_present
);
    initial begin
        o_data_event = 1'b0;
        o_error_event = 1'b0;
        o_energy_present = 1'b0;
    end
    // 3 high, 4 low so every edge survives the synchroniser
    task automatic send(input int nd, input int ne);
        repeat (nd + ne) begin
            @(posedge i_mclk);
            if (ne > 0) o_error_event <= 1'b1;
            else o_data_event <= 1'b1;
            repeat (3) @(posedge i_mclk);
            o_error_event <= 1'b0;
            o_data_event <= 1'b0;
            repeat (3) @(posedge i_mclk);
            ne--;
        end
    endtask
    task automatic set_energy(input logic v);
        @(posedge i_mclk);
        o_energy_present <= v;
    endtask
endmodule

/* File: edpc_pkg.sv */
package edpc_pkg;

    localparam logic [11:0] ADDR_ENERGY_DETECT_CONTROL = 12'h000;
    localparam logic [11:0] ADDR_IST  = 12'h004;
    localparam logic [11:0] ADDR_ICLR = 12'h008;
    localparam logic [11:0] ADDR_IEN  = 12'h00c;

    localparam int BIT_EN        = 15;
    localparam int BIT_WAKE      = 14;
    localparam int BIT_SLEEP     = 13;
    localparam int BIT_MAN       = 12;
    localparam int BIT_BURST_DIS = 11;
    localparam int BIT_PWR       = 10;
    localparam int BIT_ERR_HIT   = 9;
    localparam int BIT_DATA_HIT  = 8;
    localparam int ERR_THR_LSB   = 4;
    localparam int DATA_THR_LSB  = 0;

    localparam logic       RST_WAKE     = 1'b1;
    localparam logic       RST_SLEEP    = 1'b1;
    localparam logic       RST_BURST    = 1'b0;
    localparam logic [3:0] RST_ERR_THR  = 4'h1;
    localparam logic [3:0] RST_DATA_THR = 4'h1;

    localparam int IRQ_PWR  = 0;
    localparam int IRQ_DATA = 1;
    localparam int IRQ_ERR  = 2;
    localparam int IRQ_N    = 3;

    localparam longint CLK_HZ        = 25_000_000;
    localparam longint IDLE_S        = 2;
    localparam longint IDLE_CYC      = CLK_HZ * IDLE_S;
    localparam longint PULSE_GAP_NS  = 1000;
    localparam longint PULSE_GAP_CYC = (PULSE_GAP_NS * CLK_HZ + 999_999_999) / 1_000_000_000;
    localparam logic [2:0] BURST_LONG  = 3'h4;
    localparam logic [2:0] BURST_SHORT = 3'h1;
    localparam logic [1:0] STRAP_WAIT  = 2'h3;

    typedef struct packed {
        logic [2:0]           strap_sync;
        logic [1:0]           strap_wait;
        logic                 strap_done;
        logic [2:0]           data_sync;
        logic [2:0]           err_sync;
        logic [2:0]           nrg_sync;
        logic                 data_lvl;
        logic                 err_lvl;
        logic                 nrg_lvl;
        logic                 en;
        logic                 auto_wake;
        logic                 auto_sleep;
        logic                 burst_dis;
        logic [3:0]           err_thr;
        logic [3:0]           data_thr;
        logic                 pwr;
        logic                 err_hit;
        logic                 data_hit;
        logic                 data_hit_seen;
        logic                 err_hit_seen;
        logic [3:0]           data_cnt;
        logic [3:0]           err_cnt;
        logic [31:0]          idle_cnt;
        logic [2:0]           burst_left;
        logic [7:0]           gap_cnt;
        logic                 pulse;
        logic [IRQ_N-1:0]     ist;
        logic [IRQ_N-1:0]     ien;
        logic [31:0]          rdata;
        logic                 slverr;
    } edpc_state_type;

endpackage

/* File: edpc_top.sv */
`timescale 1ns/10ps
// Summary of operation
// - Low-power operation runs only while the enable bit 15 is set, and that bit starts from a strap.
// - With auto wake set, the driver powers up once the data event count reaches the data threshold.
// - With auto sleep set, the driver powers down once no energy is seen on the line.
// - Writing one to bit 12 toggles the power state regardless of thresholds and timers, self-clearing.
// - Each power-up sends four data pulses, or only one while the burst disable bit 11 is set.
// - Read-only bit 10 shows one when powered up and zero when powered down.
// - Bit 9 is set when the error count reaches its threshold, also raises interrupt status bit 2, and clears on read.
// - Bit 8 is set when the data count reaches or passes the data threshold and clears on read.
// - Bits 7:4 hold a writable error event threshold that resets to one.
// - Bits 3:0 hold a writable data event threshold that resets to one.
// - Both event counters return to zero after two seconds without a data event.
module edpc_top #(
    parameter int IDLE_CYCLES = int'(edpc_pkg::IDLE_CYC)
) (
    input  wire logic        i_mclk,
    input  wire logic        i_reset,
    input  wire logic        i_strap_enable,
    input  wire logic        i_data_event,
    input  wire logic        i_error_event,
    input  wire logic        i_energy_present,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic             pready,
    output logic [31:0]      prdata,
    output logic             pslverr,
    output logic             o_line_driver_on,
    output logic             o_sense_pulse,
    output logic             o_irq
);

    localparam int IRQ_W = edpc_pkg::IRQ_N;

    edpc_pkg::edpc_state_type state_r;
    edpc_pkg::edpc_state_type state_nxt;

    logic        setup;
    logic        access;
    logic        wr;
    logic        rd_ctrl;
    logic        man_wr;
    logic        data_rise;
    logic        err_rise;
    logic        data_met;
    logic        err_met;
    logic        go_up;
    logic        go_down;
    logic        sel_ctrl;
    logic        sel_ist;
    logic        sel_iclr;
    logic        sel_ien;
    logic [15:0] ctrl_view;
    logic [2:0]  ev;

    assign setup  = psel & ~penable;
    assign access = psel & penable;
    assign wr     = access & pwrite;
    assign pready = access;
    assign prdata  = state_r.rdata;
    assign pslverr = access & state_r.slverr;
    assign o_line_driver_on = ~state_r.en | state_r.pwr;
    assign o_sense_pulse    = state_r.pulse;
    assign o_irq            = |(state_r.ist & state_r.ien);

    always_comb begin
        ctrl_view = 16'h0000;
        ctrl_view[edpc_pkg::BIT_EN]        = state_r.en;
        ctrl_view[edpc_pkg::BIT_WAKE]      = state_r.auto_wake;
        ctrl_view[edpc_pkg::BIT_SLEEP]     = state_r.auto_sleep;
        ctrl_view[edpc_pkg::BIT_BURST_DIS] = state_r.burst_dis;
        ctrl_view[edpc_pkg::BIT_PWR]       = state_r.pwr;
        ctrl_view[edpc_pkg::BIT_ERR_HIT]   = state_r.err_hit;
        ctrl_view[edpc_pkg::BIT_DATA_HIT]  = state_r.data_hit;
        ctrl_view[edpc_pkg::ERR_THR_LSB +: 4]  = state_r.err_thr;
        ctrl_view[edpc_pkg::DATA_THR_LSB +: 4] = state_r.data_thr;
    end

    // one-hot register select from the bus address
    always_comb begin
        sel_ctrl = 1'b0;
        sel_ist  = 1'b0;
        sel_iclr = 1'b0;
        sel_ien  = 1'b0;
        if (paddr == edpc_pkg::ADDR_ENERGY_DETECT_CONTROL) begin
            sel_ctrl = 1'b1;
        end else if (paddr == edpc_pkg::ADDR_IST) begin
            sel_ist = 1'b1;
        end else if (paddr == edpc_pkg::ADDR_ICLR) begin
            sel_iclr = 1'b1;
        end else if (paddr == edpc_pkg::ADDR_IEN) begin
            sel_ien = 1'b1;
        end
    end

    always_comb begin
        state_nxt = state_r;
        ev        = 3'h0;

        // pins pass three stages; a level counts once stages two and three agree
        state_nxt.strap_sync = {state_r.strap_sync[1:0], i_strap_enable};
        state_nxt.data_sync  = {state_r.data_sync[1:0], i_data_event};
        state_nxt.err_sync   = {state_r.err_sync[1:0], i_error_event};
        state_nxt.nrg_sync   = {state_r.nrg_sync[1:0], i_energy_present};
        if (state_r.data_sync[2] == state_r.data_sync[1]) begin
            state_nxt.data_lvl = state_r.data_sync[2];
        end
        if (state_r.err_sync[2] == state_r.err_sync[1]) begin
            state_nxt.err_lvl = state_r.err_sync[2];
        end
        if (state_r.nrg_sync[2] == state_r.nrg_sync[1]) begin
            state_nxt.nrg_lvl = state_r.nrg_sync[2];
        end
        data_rise = state_nxt.data_lvl & ~state_r.data_lvl;
        err_rise  = state_nxt.err_lvl & ~state_r.err_lvl;

        // strap is caught once the synchroniser has filled after reset release
        if (!state_r.strap_done) begin
            if (state_r.strap_wait == edpc_pkg::STRAP_WAIT) begin
                if (state_r.strap_sync[2] == state_r.strap_sync[1]) begin
                    state_nxt.en         = state_r.strap_sync[2];
                    state_nxt.strap_done = 1'b1;
                end
            end else begin
                state_nxt.strap_wait = state_r.strap_wait + 2'h1;
            end
        end

        // event counters, saturating, cleared after the idle time
        if (data_rise) begin
            state_nxt.idle_cnt = 32'h0;
            if (state_r.data_cnt != 4'hf) begin
                state_nxt.data_cnt = state_r.data_cnt + 4'h1;
            end
        end else if (state_r.idle_cnt >= 32'(IDLE_CYCLES - 1)) begin
            state_nxt.idle_cnt = 32'h0;
            state_nxt.data_cnt = 4'h0;
            state_nxt.err_cnt  = 4'h0;
        end else begin
            state_nxt.idle_cnt = state_r.idle_cnt + 32'h1;
        end
        if (err_rise && state_nxt.err_cnt != 4'hf) begin
            state_nxt.err_cnt = state_nxt.err_cnt + 4'h1;
        end

        // apb: data captured in setup, effects at the completing access edge
        if (setup) begin
            state_nxt.slverr = 1'b0;
            state_nxt.rdata  = 32'h0;
            if (sel_ctrl) begin
                state_nxt.rdata = {16'h0000, ctrl_view};
            end else if (sel_ist) begin
                state_nxt.rdata = {29'h0, state_r.ist};
            end else if (sel_iclr) begin
                state_nxt.rdata = 32'h0;
            end else if (sel_ien) begin
                state_nxt.rdata = {29'h0, state_r.ien};
            end else begin
                state_nxt.slverr = 1'b1;
            end
        end
        rd_ctrl = access & ~pwrite & sel_ctrl;
        man_wr  = 1'b0;
        if (rd_ctrl) begin
            state_nxt.err_hit  = 1'b0;
            state_nxt.data_hit = 1'b0;
        end
        if (wr && sel_ctrl) begin
            state_nxt.en         = pwdata[edpc_pkg::BIT_EN];
            state_nxt.strap_done = 1'b1;
            state_nxt.auto_wake  = pwdata[edpc_pkg::BIT_WAKE];
            state_nxt.auto_sleep = pwdata[edpc_pkg::BIT_SLEEP];
            state_nxt.burst_dis  = pwdata[edpc_pkg::BIT_BURST_DIS];
            state_nxt.err_thr    = pwdata[edpc_pkg::ERR_THR_LSB +: 4];
            state_nxt.data_thr   = pwdata[edpc_pkg::DATA_THR_LSB +: 4];
            man_wr               = pwdata[edpc_pkg::BIT_MAN];
        end
        if (wr && sel_ien) begin
            state_nxt.ien = pwdata[IRQ_W-1:0];
        end
        if (wr && sel_iclr) begin
            state_nxt.ist = state_r.ist & ~pwdata[IRQ_W-1:0];
        end

        // threshold flags, a new hit wins over the read clear
        data_met = state_r.data_cnt >= state_r.data_thr;
        err_met  = (state_r.err_cnt >= state_r.err_thr) && (state_r.err_cnt != 4'h0);
        if (data_met && !state_r.data_hit_seen) begin
            state_nxt.data_hit = 1'b1;
            ev[edpc_pkg::IRQ_DATA] = 1'b1;
        end
        if (err_met && !state_r.err_hit_seen) begin
            state_nxt.err_hit = 1'b1;
            ev[edpc_pkg::IRQ_ERR] = 1'b1;
        end
        state_nxt.data_hit_seen = data_met;
        state_nxt.err_hit_seen  = err_met;

        // power state control; manual toggle overrides the automatic paths
        go_up   = state_r.en & state_r.auto_wake & ~state_r.pwr
                  & (state_r.data_cnt >= state_r.data_thr);
        go_down = state_r.en & state_r.auto_sleep & state_r.pwr
                  & ~state_r.nrg_lvl;
        if (state_r.en && man_wr) begin
            state_nxt.pwr = ~state_r.pwr;
        end else if (go_up) begin
            state_nxt.pwr = 1'b1;
        end else if (go_down) begin
            state_nxt.pwr = 1'b0;
        end
        if (state_nxt.pwr != state_r.pwr) begin
            ev[edpc_pkg::IRQ_PWR] = 1'b1;
            state_nxt.data_cnt = 4'h0;
            state_nxt.err_cnt  = 4'h0;
            state_nxt.idle_cnt = 32'h0;
        end

        // data pulse burst on each power-up
        state_nxt.pulse = 1'b0;
        if (state_nxt.pwr && !state_r.pwr) begin
            state_nxt.burst_left = state_r.burst_dis ? edpc_pkg::BURST_SHORT
                                                     : edpc_pkg::BURST_LONG;
            state_nxt.gap_cnt    = 8'h0;
        end else if (!state_nxt.pwr) begin
            // a burst cut by power-down stops before a pulse leaves with the driver off
            state_nxt.burst_left = 3'h0;
        end else if (state_r.burst_left != 3'h0) begin
            if (state_r.gap_cnt == 8'h0) begin
                state_nxt.pulse      = 1'b1;
                state_nxt.burst_left = state_r.burst_left - 3'h1;
                state_nxt.gap_cnt    = 8'(edpc_pkg::PULSE_GAP_CYC - 1);
            end else begin
                state_nxt.gap_cnt = state_r.gap_cnt - 8'h1;
            end
        end

        state_nxt.ist = state_nxt.ist | ev;
    end

    always_ff @(posedge i_mclk or posedge i_reset) begin
        if (i_reset) begin
            state_r            <= '0;
            state_r.auto_wake  <= edpc_pkg::RST_WAKE;
            state_r.auto_sleep <= edpc_pkg::RST_SLEEP;
            state_r.burst_dis  <= edpc_pkg::RST_BURST;
            state_r.err_thr    <= edpc_pkg::RST_ERR_THR;
            state_r.data_thr   <= edpc_pkg::RST_DATA_THR;
        end else begin
            state_r <= state_nxt;
        end
    end

endmodule

/* File: edpc_top_test.sv */
`timescale 1ns/10ps
module edpc_top_test;
    logic        i_mclk, i_reset, i_strap_enable, psel, penable, pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata;
    logic        pready, pslverr, o_line_driver_on, o_sense_pulse, o_irq, dev, eev, nrg;
    logic [32:0] exp_q[$];
    int          failures, compares, pulses, seed;
    edpc_top #(.IDLE_CYCLES(200)) uut (.i_mclk(i_mclk), .i_reset(i_reset),
        .i_strap_enable(i_strap_enable), .i_data_event(dev), .i_error_event(eev),
        .i_energy_present(nrg), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
        .o_line_driver_on(o_line_driver_on), .o_sense_pulse(o_sense_pulse), .o_irq(o_irq));
    edpc_partner lp (.i_mclk(i_mclk), .o_data_event(dev), .o_error_event(eev),
        .o_energy_present(nrg));
    initial begin
        i_mclk = 1'b0;
        forever #20 i_mclk = ~i_mclk;
    end
    task automatic give_verdict;
        $display("compares %0d failures %0d", compares, failures);
        if (failures == 0 && compares > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    task automatic check(input string nm, input logic [32:0] e, input logic [32:0] g);
        compares++;
        if (g !== e) begin
            failures++;
            $display("mismatch %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                       input logic [32:0] e);
        int n;
        @(posedge i_mclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        if (!w) exp_q.push_back(e);
        @(posedge i_mclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge i_mclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (n >= 50) begin
            failures++;
            give_verdict();
        end
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wait_drv(input logic v);
        int n;
        n = 0;
        while (o_line_driver_on !== v && n < 2000) begin
            @(negedge i_mclk);
            n++;
        end
        check("line_driver", 33'(v), 33'(o_line_driver_on));
        if (n >= 2000) give_verdict();
    endtask
    // oldest noted read result against what the bus returns
    always @(posedge i_mclk) begin
        if (psel && penable && !pwrite && pready === 1'b1) begin
            check("read", exp_q[0], {pslverr, prdata});
            void'(exp_q.pop_front());
        end
    end
    always @(posedge i_mclk) if (o_sense_pulse === 1'b1) pulses++;
    initial begin
        {failures, compares, pulses, seed} = {32'd0, 32'd0, 32'd0, 32'd59248};
        {i_reset, i_strap_enable, psel, penable, pwrite, paddr, pwdata} = '0;
        i_reset = 1'b1;
        i_strap_enable = 1'b1;
        repeat (2) @(posedge i_mclk);
        i_reset <= 1'b0;
        repeat (8) @(posedge i_mclk);
        apb(1'b0, 12'h000, 32'h0, 33'he011);
        apb(1'b0, 12'h00c, 32'h0, 33'h0);
        apb(1'b1, 12'h010, $random(seed), 33'h0);
        apb(1'b1, 12'h004, $random(seed), 33'h0);
        apb(1'b0, 12'h010, 32'h0, 33'h100000000);
        apb(1'b0, 12'h004, 32'h0, 33'h0);
        wait_drv(1'b0);
        apb(1'b1, 12'h00c, 32'h1, 33'h0);
        apb(1'b1, 12'h000, 32'he023, 33'h0);
        apb(1'b0, 12'h000, 32'h0, 33'he023);
        lp.set_energy(1'b1);
        lp.send(0, 2);
        lp.send(3, 0);
        wait_drv(1'b1);
        repeat (120) @(negedge i_mclk);
        check("pulses", 33'h4, 33'(pulses));
        check("irq", 33'h1, 33'(o_irq));
        apb(1'b0, 12'h000, 32'h0, 33'he723);
        apb(1'b0, 12'h000, 32'h0, 33'he423);
        apb(1'b0, 12'h004, 32'h0, 33'h7);
        apb(1'b1, 12'h008, 32'h7, 33'h0);
        apb(1'b0, 12'h004, 32'h0, 33'h0);
        @(negedge i_mclk);
        check("irq", 33'h0, 33'(o_irq));
        pulses = 0;
        apb(1'b1, 12'h000, 32'hf823, 33'h0);
        wait_drv(1'b0);
        apb(1'b0, 12'h000, 32'h0, 33'he823);
        apb(1'b1, 12'h000, 32'hf823, 33'h0);
        wait_drv(1'b1);
        repeat (60) @(negedge i_mclk);
        check("pulses", 33'h1, 33'(pulses));
        lp.set_energy(1'b0);
        wait_drv(1'b0);
        apb(1'b1, 12'h000, 32'h6823, 33'h0);
        wait_drv(1'b1);
        apb(1'b1, 12'h000, 32'he823, 33'h0);
        wait_drv(1'b0);
        lp.set_energy(1'b1);
        lp.send(2, 0);
        repeat (260) @(negedge i_mclk);
        lp.send(1, 0);
        repeat (40) @(negedge i_mclk);
        check("line_driver", 33'h0, 33'(o_line_driver_on));
        lp.send(2, 0);
        wait_drv(1'b1);
        give_verdict();
    end
endmodule
